/* char_lcd_pkg.sv */
package char_lcd_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CLK_MHZ          = 200;
  localparam int unsigned OSC_KHZ          = 270;
  localparam int unsigned LONG_EXEC_NS     = 1520000;
  localparam int unsigned SHORT_EXEC_NS    = 37000;
  // one oscillator period expressed in system cycles, rounded down
  localparam int unsigned OSC_DIV_CYCLES   = (CLK_MHZ * 1000) / OSC_KHZ;
  localparam int unsigned LONG_EXEC_CYC    = (LONG_EXEC_NS * CLK_MHZ) / 1000;
  localparam int unsigned SHORT_EXEC_CYC   = (SHORT_EXEC_NS * CLK_MHZ) / 1000;
  localparam int unsigned ADDR_UPD_CYC     = 2;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [6:0] AC_RST            = 7'h00;
  localparam logic [7:0] SPACE_CODE        = 8'h20;
  // ----------------------------------------
  // ram sizes and selection
  // ----------------------------------------
  localparam int unsigned CC_DEPTH         = 128;
  localparam int unsigned GLYPH_DEPTH      = 64;
  localparam int unsigned SEG_DEPTH        = 16;
  typedef enum logic [1:0] {RAM_CC, RAM_GLYPH, RAM_SEG} ram_sel_t;
endpackage

/* char_lcd_instruction_decoder.sv */
`timescale 1ns/1ps
// Function
// - blink and low-power writable only when extended
// - bus width selects eight or two nibbles
// - line count from two-line and four-line
// - extended fields blocked and held otherwise
// - blink enable drives blinking of the selected char, glyph or segment ram
// - shift codes move cursor or display
// - low-power divides clock by four or two
// - glyph address set loads six bits
// - segment address set loads three scroll line bits and four address bits
// - char address set loads seven bits
// - char address range is the same in every line mode
// - scroll dot count zero to forty-eight
// - scroll enable stores four line bits
// - status read returns busy and address
// - data write stores byte then steps address
// - data read steps address, never shifts
// - low-prefix instruction decode
// - high-prefix instruction decode
// - execution budgets for long and short
// - address steps after busy clears
// - entry direction selects increment or decrement
// - instructions arriving while busy discarded
module char_lcd_instruction_decoder #(
  parameter int unsigned LONG_CYC  = char_lcd_pkg::LONG_EXEC_CYC,
  parameter int unsigned SHORT_CYC = char_lcd_pkg::SHORT_EXEC_CYC
) (
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic       i_cmd_data_select,
  input  wire logic [7:0] i_data_lines,
  input  wire logic       i_extension_driver_pin,
  output logic [7:0]      o_data_lines,
  output logic            o_busy_flag,
  output logic [6:0]      o_address_counter,
  output logic            o_bus_width_select,
  output logic [1:0]      o_line_mode,
  output logic            o_pattern_blink_enable,
  output logic            o_low_power_active,
  output logic [1:0]      o_clk_div,
  output logic            o_ext_access_enable,
  output logic            o_six_dot_font_select,
  output logic            o_invert_cursor,
  output logic            o_display_on,
  output logic            o_cursor_on,
  output logic            o_cursor_blink,
  output logic            o_entry_inc,
  output logic            o_entry_shift,
  output logic signed [7:0] o_display_offset,
  output logic [5:0]      o_scroll_dot_count,
  output logic [2:0]      o_scroll_line_field,
  output logic [3:0]      o_scroll_line_enable,
  output logic [7:0]      o_blink_attr
);
  import char_lcd_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum {ST_IDLE, ST_BUSY, ST_ADDR_UPD} state_t;
  state_t      state;
  logic [7:0]  cc_ram    [CC_DEPTH];
  logic [7:0]  glyph_ram [GLYPH_DEPTH];
  logic [7:0]  seg_ram   [SEG_DEPTH];
  ram_sel_t    ram_sel;
  logic [6:0]  address_counter;
  logic        ext_access_enable;
  logic        bus_width_select;
  logic        two_line_select;
  logic        four_line_select;
  logic        pattern_blink_enable;
  logic        low_power_select;
  logic        six_dot_font_select;
  logic        invert_cursor;
  logic        nib_phase;
  logic [3:0]  nib_hold;
  logic        rd_phase;
  logic [31:0] exec_cnt;
  logic [31:0] upd_cnt;
  logic        pend_step;
  logic        clr_busy;
  logic [6:0]  clr_idx;

  // ----------------------------------------
  // byte assembly, four-bit mode
  // ----------------------------------------
  wire        byte_done = i_wr & (bus_width_select | nib_phase);
  wire [7:0]  wbyte     = bus_width_select ? i_data_lines
                                           : {nib_hold, i_data_lines[7:4]};
  wire        rd_done   = i_rd & (bus_width_select | rd_phase);
  wire        idle      = (state == ST_IDLE);
  wire        accept    = byte_done & idle;
  wire        is_cmd    = accept & ~i_cmd_data_select;
  wire        is_dwr    = accept & i_cmd_data_select;
  wire        is_drd    = rd_done & i_cmd_data_select & idle;

  // ----------------------------------------
  // instruction decode by leading one
  // ----------------------------------------
  wire d_clear  = is_cmd & (wbyte == 8'h01);
  wire d_home   = is_cmd & (wbyte[7:1] == 7'h01);
  wire d_entry  = is_cmd & (wbyte[7:2] == 6'h01);
  wire d_disp   = is_cmd & (wbyte[7:3] == 5'h01) & ~ext_access_enable;
  wire d_extfn  = is_cmd & (wbyte[7:3] == 5'h01) &  ext_access_enable;
  wire d_shift  = is_cmd & (wbyte[7:4] == 4'h1) & ~ext_access_enable;
  wire d_scren  = is_cmd & (wbyte[7:4] == 4'h1) &  ext_access_enable;
  wire d_func   = is_cmd & (wbyte[7:5] == 3'h1);
  wire d_glyph  = is_cmd & (wbyte[7:6] == 2'h1) & ~ext_access_enable;
  wire d_seg    = is_cmd & (wbyte[7:6] == 2'h1) &  ext_access_enable;
  wire d_cc     = is_cmd & wbyte[7] & ~ext_access_enable;
  wire d_sq     = is_cmd & wbyte[7] &  ext_access_enable;
  wire long_ins = d_clear | d_home;

  // ----------------------------------------
  // low-power clock division and budgets
  // ----------------------------------------
  wire        lp_active = low_power_select & ~i_extension_driver_pin;
  wire        one_line  = ~four_line_select & ~two_line_select;
  wire [1:0]  line_mode = four_line_select ? 2'd2 : {1'b0, two_line_select};
  wire [2:0]  div       = ~lp_active ? 3'd1 : (one_line ? 3'd4 : 3'd2);
  wire [31:0] budget    = (long_ins ? LONG_CYC : SHORT_CYC) * {29'd0, div};

  // ----------------------------------------
  // address stepping
  // ----------------------------------------
  logic        entry_inc;
  logic        entry_shift;
  logic signed [7:0] disp_off;
  wire  [6:0]  ac_mask   = (ram_sel == RAM_GLYPH) ? 7'h3f : ((ram_sel == RAM_SEG) ? 7'h0f : 7'h7f);
  wire  [6:0]  ac_step   = entry_inc ? address_counter + 7'd1 : address_counter - 7'd1;
  wire  [6:0]  next_ac   = ac_step & ac_mask;
  wire  [7:0]  rd_byte   = (ram_sel == RAM_GLYPH) ? glyph_ram[address_counter[5:0]] :
                           (ram_sel == RAM_SEG)   ? seg_ram[address_counter[3:0]]   :
                                                    cc_ram[address_counter];

  // ----------------------------------------
  // bus phase tracking
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      nib_phase <= 1'b0;
      nib_hold  <= 4'h0;
      rd_phase  <= 1'b0;
    end else begin
      if (i_wr & ~bus_width_select) begin
        nib_phase <= ~nib_phase;
        nib_hold  <= i_data_lines[7:4];
      end
      if (i_rd & ~bus_width_select) begin
        rd_phase <= ~rd_phase;
      end
      if (d_func & wbyte[4]) begin
        nib_phase <= 1'b0;
        rd_phase  <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // status and data readback
  // ----------------------------------------
  logic [7:0] rd_word;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_word      <= 8'h00;
      o_data_lines <= 8'h00;
    end else begin
      if (i_rd & (bus_width_select | ~rd_phase)) begin
        rd_word <= i_cmd_data_select ? rd_byte : {o_busy_flag, address_counter};
      end
      if (i_rd) begin
        if (bus_width_select) begin
          o_data_lines <= i_cmd_data_select ? rd_byte : {o_busy_flag, address_counter};
        end else if (!rd_phase) begin
          o_data_lines <= {(i_cmd_data_select ? rd_byte[7:4] : {o_busy_flag, address_counter[6:4]}), 4'h0};
        end else begin
          o_data_lines <= {rd_word[3:0], 4'h0};
        end
      end
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ext_access_enable    <= 1'b0;
      bus_width_select     <= 1'b1;
      two_line_select      <= 1'b0;
      four_line_select     <= 1'b0;
      pattern_blink_enable <= 1'b0;
      low_power_select     <= 1'b0;
      six_dot_font_select  <= 1'b0;
      invert_cursor        <= 1'b0;
      o_display_on         <= 1'b0;
      o_cursor_on          <= 1'b0;
      o_cursor_blink       <= 1'b0;
      entry_inc            <= 1'b1;
      entry_shift          <= 1'b0;
      o_scroll_dot_count   <= 6'h00;
      o_scroll_line_field  <= 3'h0;
      o_scroll_line_enable <= 4'h0;
    end else begin
      if (d_func) begin
        bus_width_select <= wbyte[4];
        two_line_select  <= wbyte[3];
        ext_access_enable <= wbyte[2];
        if (ext_access_enable) begin
          pattern_blink_enable <= wbyte[1];
          low_power_select     <= wbyte[0];
        end
      end
      if (d_extfn) begin
        six_dot_font_select <= wbyte[2];
        invert_cursor       <= wbyte[1];
        four_line_select    <= wbyte[0];
      end
      if (d_disp) begin
        o_display_on   <= wbyte[2];
        o_cursor_on    <= wbyte[1];
        o_cursor_blink <= wbyte[0];
      end
      if (d_entry) begin
        entry_inc   <= wbyte[1];
        entry_shift <= wbyte[0];
      end
      if (d_clear) begin
        entry_inc <= 1'b1;
      end
      if (d_shift) begin
        ext_access_enable <= 1'b0;
      end
      if (d_scren) begin
        o_scroll_line_enable <= wbyte[3:0];
      end
      if (d_seg) begin
        o_scroll_line_field <= wbyte[5:3];
      end
      if (d_sq) begin
        o_scroll_dot_count <= (wbyte[5:0] > 6'd48) ? 6'd48 : wbyte[5:0];
      end
    end
  end

  // ----------------------------------------
  // sequencer, address counter, display shift
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state           <= ST_IDLE;
      exec_cnt        <= 32'd0;
      upd_cnt         <= 32'd0;
      pend_step       <= 1'b0;
      address_counter <= AC_RST;
      ram_sel         <= RAM_CC;
      disp_off        <= 8'sd0;
      clr_busy        <= 1'b0;
      clr_idx         <= 7'd0;
    end else begin
      // fill progress first, so a new clear restarts the fill
      if (clr_busy) begin
        clr_idx <= clr_idx + 7'd1;
        if (clr_idx == 7'h7f) begin
          clr_busy <= 1'b0;
        end
      end
      unique case (state)
        ST_IDLE: begin
          if (accept | is_drd) begin
            state    <= ST_BUSY;
            exec_cnt <= budget - 32'd1;
          end
          if (is_dwr | is_drd) begin
            pend_step <= 1'b1;
          end
          if (d_clear | d_home) begin
            address_counter <= AC_RST;
            ram_sel         <= RAM_CC;
            disp_off        <= 8'sd0;
          end
          if (d_clear) begin
            clr_busy <= 1'b1;
            clr_idx  <= 7'd0;
          end
          if (d_glyph) begin
            address_counter <= {1'b0, wbyte[5:0]};
            ram_sel         <= RAM_GLYPH;
          end
          if (d_seg) begin
            address_counter <= {3'b000, wbyte[3:0]};
            ram_sel         <= RAM_SEG;
          end
          if (d_cc) begin
            address_counter <= wbyte[6:0];
            ram_sel         <= RAM_CC;
          end
          if (d_shift) begin
            unique case (wbyte[3:2])
              2'b00: address_counter <= address_counter - 7'd1;
              2'b01: address_counter <= address_counter + 7'd1;
              2'b10: disp_off <= disp_off - 8'sd1;
              2'b11: disp_off <= disp_off + 8'sd1;
            endcase
          end
          if (is_dwr & entry_shift & (ram_sel == RAM_CC)) begin
            disp_off <= entry_inc ? disp_off - 8'sd1 : disp_off + 8'sd1;
          end
        end
        ST_BUSY: begin
          if (exec_cnt != 32'd0) begin
            exec_cnt <= exec_cnt - 32'd1;
          end else if (pend_step) begin
            state   <= ST_ADDR_UPD;
            upd_cnt <= 32'(ADDR_UPD_CYC);
          end else begin
            state <= ST_IDLE;
          end
        end
        ST_ADDR_UPD: begin
          if (upd_cnt != 32'd0) begin
            upd_cnt <= upd_cnt - 32'd1;
          end else begin
            address_counter <= next_ac;
            pend_step       <= 1'b0;
            state           <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // ram writes
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (clr_busy) begin
      cc_ram[clr_idx] <= SPACE_CODE;
    end else if (is_dwr) begin
      unique case (ram_sel)
        RAM_GLYPH: glyph_ram[address_counter[5:0]] <= wbyte;
        RAM_SEG:   seg_ram[address_counter[3:0]]   <= wbyte;
        default:   cc_ram[address_counter]         <= wbyte;
      endcase
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign o_busy_flag            = (state == ST_BUSY);
  assign o_address_counter      = address_counter;
  assign o_bus_width_select     = bus_width_select;
  assign o_line_mode            = line_mode;
  assign o_pattern_blink_enable = pattern_blink_enable;
  assign o_blink_attr           = pattern_blink_enable ? {rd_byte[7:6], 6'h00} : 8'h00;
  assign o_low_power_active     = lp_active;
  assign o_clk_div              = div[2] ? 2'd2 : (div[1] ? 2'd1 : 2'd0);
  assign o_ext_access_enable    = ext_access_enable;
  assign o_six_dot_font_select  = six_dot_font_select;
  assign o_invert_cursor        = invert_cursor;
  assign o_entry_inc            = entry_inc;
  assign o_entry_shift          = entry_shift;
  assign o_display_offset       = disp_off;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_busy_discard: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (byte_done & ~idle & ~i_cmd_data_select) |=> $stable(ext_access_enable)) else $error("write while busy took effect");
  a_blocked_ext: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (d_func & ~ext_access_enable) |=> $stable(low_power_select) && $stable(pattern_blink_enable))
    else $error("extended bits changed while gate closed");
  a_busy_set: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    accept |=> o_busy_flag) else $error("busy not raised");
  a_ac_hold: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (state == ST_BUSY) && pend_step |=> $stable(address_counter)) else $error("address moved while busy");
  a_glyph_load: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    d_glyph |=> address_counter == {1'b0, $past(wbyte[5:0])} && ram_sel == RAM_GLYPH)
    else $error("glyph address not loaded");
  a_scroll_max: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    o_scroll_dot_count <= 6'd48) else $error("scroll count above limit");
  a_lp_div: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    lp_active && one_line |-> div == 3'd4) else $error("low power divide wrong");
  a_read_noshift: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    is_drd && !is_cmd |=> $stable(disp_off)) else $error("read shifted display");
endmodule // char_lcd_instruction_decoder

/* host_bus_model.sv */
`timescale 1ns/1ps
module host_bus_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  output logic            o_wr,
  output logic            o_rd,
  output logic            o_rs,
  output logic [7:0]      o_data
);
  // ----------------------------------------
  // bus cycles, whole bytes or nibble pairs
  // ----------------------------------------
  logic nibble_mode;
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_rs = 1'b0;
    o_data = 8'h00;
    nibble_mode = 1'b0;
  end
  task automatic strobe(input logic rs, input logic wr, input logic [7:0] d);
    @(posedge i_clk);
    o_rs <= rs;
    o_wr <= wr;
    o_rd <= ~wr;
    o_data <= d;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    o_data <= ~d;  // released lines never keep the last value
  endtask
  task automatic put(input logic rs, input logic [7:0] d);
    if (nibble_mode) begin
      strobe(rs, 1'b1, {d[7:4], 4'hf});
      strobe(rs, 1'b1, {d[3:0], 4'hf});
    end else begin
      strobe(rs, 1'b1, d);
    end
    if (!rs && d[7:5] == 3'b001) begin
      nibble_mode = ~d[4];
    end
  endtask
  task automatic get(input logic rs, output logic [7:0] d);
    strobe(rs, 1'b0, 8'h00);
    @(posedge i_clk);
    d = i_rdata;
    if (nibble_mode) begin
      strobe(rs, 1'b0, 8'h00);
      @(posedge i_clk);
      d[3:0] = i_rdata[7:4];
    end
  endtask
  task automatic wait_idle(output logic ok);
    logic [7:0] st;
    ok = 1'b0;
    for (int i = 0; i < 200 && !ok; i++) begin
      get(1'b0, st);
      ok = (st[7] === 1'b0);
    end
  endtask
endmodule // host_bus_model

/* test_char_lcd_instruction_decoder.sv */
`timescale 1ns/1ps
module test_char_lcd_instruction_decoder;
  import char_lcd_pkg::*;
  localparam int unsigned LONG  = 20;
  localparam int unsigned SHORT = 5;
  localparam logic [7:0]  SQ [3] = '{8'h85, 8'hb0, 8'hbf};
  localparam logic [7:0]  SX [3] = '{8'h05, 8'h30, 8'h30};
  localparam logic [7:0]  SH [4] = '{8'h10, 8'h14, 8'h18, 8'h1c};
  localparam logic [7:0]  SA [4] = '{8'h4f, 8'h50, 8'h50, 8'h50};
  localparam logic [7:0]  SO [4] = '{8'h00, 8'h00, 8'hff, 8'h00};
  logic       i_clk, i_arst_n, wr, rd, rs, ext_pin, busy, bw, blink, lpa, ea, font, inv, dsp, cur, cb, inc, shf;
  logic [1:0] lines, div;
  logic [2:0] slf;
  logic [3:0] sle;
  logic [5:0] sdc;
  logic [6:0] ac;
  logic [7:0] wdata, rdata, off, s, battr;
  int         mismatches = 0;
  int         checks_done = 0;
  int         n;
  char_lcd_instruction_decoder #(.LONG_CYC(LONG), .SHORT_CYC(SHORT)) dut (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_wr(wr), .i_rd(rd), .i_cmd_data_select(rs),
    .i_data_lines(wdata), .i_extension_driver_pin(ext_pin), .o_data_lines(rdata), .o_busy_flag(busy),
    .o_address_counter(ac), .o_bus_width_select(bw), .o_line_mode(lines), .o_pattern_blink_enable(blink),
    .o_low_power_active(lpa), .o_clk_div(div), .o_ext_access_enable(ea), .o_six_dot_font_select(font),
    .o_invert_cursor(inv), .o_display_on(dsp), .o_cursor_on(cur), .o_cursor_blink(cb), .o_entry_inc(inc),
    .o_entry_shift(shf), .o_display_offset(off), .o_scroll_dot_count(sdc), .o_scroll_line_field(slf),
    .o_scroll_line_enable(sle), .o_blink_attr(battr));
  host_bus_model host (.i_clk(i_clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd), .o_rs(rs), .o_data(wdata));
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  // ----------------------------------------
  // shared helpers
  // ----------------------------------------
  task automatic conclude;
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic give_up;
    mismatches++;
    $display("[FAIL] t=%0t wait bound exhausted got=%h exp=%h", $time, 8'h00, 8'h01);
    conclude();
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic idle;
    logic ok;
    host.wait_idle(ok);
    if (ok !== 1'b1) give_up();
    #1;
  endtask
  task automatic cmd(input logic [7:0] d);
    host.put(1'b0, d);
    idle();
  endtask
  task automatic busy_len(output int cnt);
    cnt = 0;
    #1;
    while (busy === 1'b1) begin
      cnt++;
      if (cnt > 400) give_up();
      @(posedge i_clk);
      #1;
    end
  endtask
  task automatic chk_busy(input int exp);
    busy_len(n);
    cmp({7'h00, n == exp || n == exp + 1}, 8'h01);
    idle();
  endtask
  task automatic settle;
    idle();
    repeat (ADDR_UPD_CYC + 2) @(posedge i_clk);
    #1;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_gate;
    cmd(8'h3b);  // width and lines set first
    cmp({blink, lpa, ea, 3'b000, lines}, 8'h01);
    cmd(8'h3c);
    cmd(8'h3f);
    cmp({blink, lpa, ea, 1'b0, div, lines}, 8'he5);
    host.put(1'b0, 8'h1a);
    chk_busy(SHORT * 2);
    cmp({4'h0, sle}, 8'h0a);
    @(posedge i_clk);
    ext_pin <= 1'b1;
    repeat (2) @(posedge i_clk);
    #1;
    cmp({lpa, 5'h00, div}, 8'h00);
    @(posedge i_clk);
    ext_pin <= 1'b0;
    cmd(8'h37);
    cmp({lpa, 3'b000, div, lines}, 8'h88);
    host.put(1'b0, 8'h37);
    chk_busy(SHORT * 4);
    cmd(8'h3c);  // low power left before any shift
  endtask
  task automatic t_ext;
    cmd(8'h0f);
    cmp({font, inv, 4'h0, lines}, 8'hc2);
    for (int i = 0; i < 3; i++) begin
      cmd(SQ[i]);
      cmp({2'b00, sdc}, SX[i]);
    end
    cmd(8'h4a);
    cmp({slf, ac[4:0]}, 8'h2a);
    cmd(8'h38);
    cmp({ea, 5'h00, lines}, 8'h02);
    cmd(8'h0f);
    cmp({dsp, cur, cb, font, inv, 3'b000}, 8'hf8);
    cmd(8'hb3);
    cmp({1'b0, ac}, 8'h33);
    cmp({2'b00, sdc}, 8'h30);
    cmd(8'h1a);
    cmp(off, 8'hff);
    cmp({4'h0, sle}, 8'h0a);
    host.put(1'b0, 8'h02);
    chk_busy(LONG);
    cmp(off, 8'h00);
  endtask
  task automatic t_addr;
    cmd(8'h6a);
    cmp({1'b0, ac}, 8'h2a);
    cmd(8'hc5);
    cmp({1'b0, ac}, 8'h45);
    host.put(1'b0, 8'hd0);
    host.put(1'b0, 8'h85);
    idle();
    cmp({1'b0, ac}, 8'h50);
  endtask
  task automatic t_shift;
    for (int i = 0; i < 4; i++) begin
      cmd(SH[i]);
      settle();
      cmp({1'b0, ac}, SA[i]);
      cmp(off, SO[i]);
    end
  endtask
  task automatic t_data;
    cmd(8'h06);
    cmd(8'h90);
    host.put(1'b1, 8'h5a);
    busy_len(n);
    cmp({1'b0, ac}, 8'h10);
    settle();
    cmp({1'b0, ac}, 8'h11);
    cmd(8'h04);
    host.put(1'b1, 8'ha5);
    settle();
    cmp({1'b0, ac}, 8'h10);
    cmd(8'h3c);
    cmd(8'h3a);
    cmp({7'h00, blink}, 8'h01);
    cmd(8'h07);
    cmp({6'h00, inc, shf}, 8'h03);
    cmd(8'h90);  // address set ahead of reads
    cmp(battr, 8'h40);
    host.get(1'b1, s);
    cmp(s, 8'h5a);
    settle();
    host.get(1'b1, s);
    cmp(s, 8'ha5);
    settle();
    cmp({1'b0, ac}, 8'h12);
    cmp(off, 8'h00);
  endtask
  task automatic t_status;
    cmd(8'h04);
    host.put(1'b0, 8'h01);
    host.get(1'b0, s);
    cmp({7'h00, s[7]}, 8'h01);
    idle();
    cmp({7'h00, inc}, 8'h01);
    host.get(1'b0, s);
    cmp(s, 8'h00);
  endtask
  task automatic t_nibble;
    cmd(8'h28);
    cmp({7'h00, bw}, 8'h00);
    cmd(8'hb3);
    host.get(1'b0, s);
    cmp(s, 8'h33);
    cmd(8'h30);
    cmp({7'h00, bw}, 8'h01);
  endtask
  initial begin
    i_arst_n = 1'b0;
    ext_pin = 1'b0;
    repeat (8) @(posedge i_clk);
    i_arst_n <= 1'b1;
    @(posedge i_clk);
    #1;
    cmp({bw, inc, ea, lpa, blink, shf, lines}, 8'hc0);
    cmp({busy, ac}, 8'h00);
    t_gate();
    t_ext();
    t_addr();
    t_shift();
    t_data();
    t_status();
    t_nibble();
    conclude();
  end
endmodule // test_char_lcd_instruction_decoder
